/* tb/jtag_probe_model.sv */
// debug probe model driving the test clock, data and mode pins
`timescale 1ns/100ps

module jtag_probe_model (
    input wire logic ref_clk,
    input wire logic tdo_level,
    output logic tck,
    output logic tdi,
    output logic tms
);
    initial begin
        tck = 1'b0;
        tdi = 1'b1;
        tms = 1'b1;
    end

    // one 160 ns test clock period; the clock rests low between frames
    task automatic clock_bit(input logic tms_v, input logic tdi_v, output logic tdo_s);
        @(posedge ref_clk);
        tms <= tms_v;
        tdi <= tdi_v;
        repeat (3) @(posedge ref_clk);
        tdo_s = tdo_level;
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b0;
        // data released after the hold: the model drives the idle level high itself
        tdi <= 1'b1;
    endtask : clock_bit

    task automatic set_tdi(input logic v);
        @(posedge ref_clk);
        tdi <= v;
    endtask : set_tdi
endmodule : jtag_probe_model

/* tb/testbench.sv */
// self-checking bench for the test-port pin block
`timescale 1ns/100ps
`include "jtag_pin_consts.svh"

module testbench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    wire logic [2:0] pin_in;
    logic [2:0] pin_out, pin_oe_b, port_d_level;
    logic p_tck, p_tdi, p_tms, role_wr, spi_ss_b, word_valid, word_ready, stall;
    logic capture_ready, word_dropped, prev_tdo, prev_oe;
    logic [5:0] role_value;
    logic [5:0] port_d_ctrl;
    logic [7:0] capture_word, word_data;
    jtag_pin_pkg::pin_roles_t roles;
    jtag_pin_pkg::tap_state_t tap_state;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 50776;
    logic [7:0] exp_q[$];
    logic [7:0] got_q[$];

    always #10 ref_clk = ~ref_clk;

    // released pins: test output has a pull-up
    assign pin_in[0] = pin_oe_b[0] ? p_tdi : pin_out[0];
    assign pin_in[1] = pin_oe_b[1] ? 1'b1 : pin_out[1];
    assign pin_in[2] = pin_oe_b[2] ? p_tck : pin_out[2];

    jtag_probe_model u_jtag_probe_model (.ref_clk(ref_clk), .tdo_level(pin_in[1]),
        .tck(p_tck), .tdi(p_tdi), .tms(p_tms));

    jtag_pin_mux #(.SHIFT_W(8), .FIFO_D(8)) u_jtag_pin_mux (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .tms_pin(p_tms),
        .role_wr(role_wr), .role_value(role_value), .roles(roles), .port_d_ctrl(port_d_ctrl),
        .port_d_level(port_d_level), .spi_ss_b(spi_ss_b), .capture_word(capture_word),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
        .capture_ready(capture_ready), .word_dropped(word_dropped), .tap_state(tap_state));

    task automatic conclude();
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic walk(input logic [7:0] seq, input int n);
        logic t;
        for (int i = 0; i < n; i++) begin
            u_jtag_probe_model.clock_bit(seq[i], 1'b1, t);
        end
    endtask : walk

    // reference shift model: lsb first, one word per eight shift clocks
    task automatic shift(input int n);
        logic b, t;
        logic [7:0] acc;
        int k;
        k = 0;
        acc = 8'h00;
        for (int i = 0; i < n; i++) begin
            b = 1'($random(seed));
            u_jtag_probe_model.clock_bit(logic'(i == n - 1), b, t);
            if (i < 8) chk(t, capture_word[i], "tdo bit");
            acc[k] = b;
            k++;
            if (k == 8) begin
                k = 0;
                if (exp_q.size() - got_q.size() < 8) exp_q.push_back(acc);
            end
        end
    endtask : shift

    task automatic drain();
        int w;
        w = 0;
        while (got_q.size() < exp_q.size() && w < 2000) begin
            @(posedge ref_clk);
            w++;
        end
        repeat (4) @(posedge ref_clk);
        chk(16'(got_q.size()), 16'(exp_q.size()), "word count");
        foreach (exp_q[j]) begin
            if (j < got_q.size()) chk(got_q[j], exp_q[j], "word");
        end
        got_q.delete();
        exp_q.delete();
    endtask : drain

    task automatic set_roles(input logic [5:0] rv, input logic [5:0] ctrl);
        @(posedge ref_clk);
        role_value <= rv;
        port_d_ctrl <= ctrl;
        role_wr <= 1'b1;
        @(posedge ref_clk);
        role_wr <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : set_roles

    always @(posedge ref_clk) begin
        word_ready <= stall ? 1'b0 : 1'($random(seed));
        if (rst_b && word_valid === 1'b1 && word_ready === 1'b1) got_q.push_back(word_data);
        // tdo may only move while the test clock is low
        if (rst_b && pin_oe_b[1] === 1'b0 && prev_oe === 1'b0 && pin_out[1] !== prev_tdo) begin
            chk(pin_in[2], 1'b0, "tdo moved with tck high");
        end
        prev_tdo <= pin_out[1];
        prev_oe <= pin_oe_b[1];
    end

    initial begin
        #400000;
        n_errors++;
        conclude();
    end

    initial begin
        logic [5:0] rv;
        logic [2:0] lvl, lv;
        logic [2:0] oe_exp;
        role_wr = 1'b0;
        role_value = 6'h00;
        port_d_ctrl = 6'h00;
        capture_word = 8'h00;
        word_ready = 1'b0;
        stall = 1'b1;
        prev_tdo = 1'b0;
        prev_oe = 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(roles, `ROLE_RESET, "roles in reset");
        chk(pin_oe_b, 3'h7, "oe in reset");
        chk(tap_state, jtag_pin_pkg::TAP_RESET, "tap in reset");
        chk(spi_ss_b, 1'b1, "ss in reset");
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        stall <= 1'b0;
        capture_word <= 8'($random(seed));
        repeat (2) @(posedge ref_clk);
        walk(8'h02, 4);
        chk(tap_state, jtag_pin_pkg::TAP_SHIFT_DR, "shift dr");
        chk(pin_oe_b[1], 1'b0, "tdo driven");
        shift(16);
        chk(tap_state, jtag_pin_pkg::TAP_EXIT1_DR, "exit1 dr");
        chk(pin_oe_b[1], 1'b1, "tdo released");
        walk(8'h07, 5);
        chk(tap_state, jtag_pin_pkg::TAP_SHIFT_IR, "shift ir");
        chk(pin_oe_b[1], 1'b0, "tdo driven ir");
        shift(8);
        walk(8'h1F, 5);
        chk(tap_state, jtag_pin_pkg::TAP_RESET, "back to reset");
        drain();
        // stalled sink: ten words offered to an eight-deep buffer
        stall <= 1'b1;
        walk(8'h02, 4);
        shift(80);
        repeat (4) @(posedge ref_clk);
        chk(capture_ready, 1'b0, "buffer full");
        chk(word_dropped, 1'b1, "overflow flagged");
        stall <= 1'b0;
        drain();
        walk(8'h1F, 5);
        for (int i = 0; i < 3; i++) begin
            rv = 6'h00;
            rv[2 * i +: 2] = `ROLE_GPIO;
            lvl = 3'($random(seed));
            set_roles(rv, {3'h7, lvl});
            lv = 3'h3;
            lv[i] = lvl[i];
            // three bits wide on purpose: a wider inversion would set the upper bits
            oe_exp = ~(3'h1 << i);
            chk(pin_oe_b, oe_exp, "port line oe");
            chk(pin_out[i], lvl[i], "port line out");
            chk(port_d_level, lv, "port line level");
        end
        // test clock as port input: edges must not step the tap
        set_roles({`ROLE_GPIO, `ROLE_GPIO, `ROLE_GPIO}, 6'h00);
        walk(8'h00, 3);
        chk(tap_state, jtag_pin_pkg::TAP_RESET, "tck ignored");
        // alternates on all pins: every pin released even with direction set
        set_roles({`ROLE_ALT, `ROLE_ALT, `ROLE_ALT}, 6'h38);
        chk(pin_oe_b, 3'h7, "alternates released");
        u_jtag_probe_model.set_tdi(1'b0);
        repeat (5) @(posedge ref_clk);
        chk(spi_ss_b, 1'b0, "ss low");
        u_jtag_probe_model.set_tdi(1'b1);
        repeat (5) @(posedge ref_clk);
        chk(spi_ss_b, 1'b1, "ss high");
        set_roles({`ROLE_GPIO, `ROLE_GPIO, `ROLE_GPIO}, 6'h3F);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(roles, `ROLE_RESET, "roles after reset");
        chk(pin_oe_b, 3'h7, "oe after reset");
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        conclude();
    end
endmodule : testbench

/* verilog/jtag_pin_consts.svh */
// constants for the test-port pin block
`ifndef JTAG_PIN_CONSTS_SVH
`define JTAG_PIN_CONSTS_SVH

// pin role codes, one two-bit field per shared pin
`define ROLE_TEST 2'h0
`define ROLE_GPIO 2'h1
`define ROLE_ALT 2'h2
// field positions inside the three-pin role word
`define ROLE_TDI_LSB 0
`define ROLE_TDO_LSB 2
`define ROLE_TCK_LSB 4
// reset value: every shared pin in its test role
`define ROLE_RESET 6'h00
// pin indices
`define PIN_TDI 0
`define PIN_TDO 1
`define PIN_TCK 2
// default shift word width and fifo depth
`define SHIFT_WIDTH 8
`define FIFO_DEPTH 8

`endif

/* verilog/jtag_pin_mux.sv */
// test-port pins shared with port d lines and the spi slave select
`timescale 1ns/100ps
`include "jtag_pin_consts.svh"

module jtag_pin_mux #(
    parameter int SHIFT_W = `SHIFT_WIDTH,
    parameter int FIFO_D = `FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_b,
    input wire logic tms_pin,
    input wire logic role_wr,
    input wire jtag_pin_pkg::pin_roles_t role_value,
    output jtag_pin_pkg::pin_roles_t roles,
    input wire jtag_pin_pkg::port_d_ctrl_t port_d_ctrl,
    output logic [2:0] port_d_level,
    output logic spi_ss_b,
    input wire logic [SHIFT_W-1:0] capture_word,
    output logic word_valid,
    input wire logic word_ready,
    output logic [SHIFT_W-1:0] word_data,
    output logic capture_ready,
    output logic word_dropped,
    output jtag_pin_pkg::tap_state_t tap_state
);
    generate
        if (SHIFT_W < 2) begin : g_bad
            $error("jtag_pin_mux: SHIFT_W must be at least 2");
        end
    endgenerate

    localparam int CW = $clog2(SHIFT_W);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [3:0] sync_meta;
    logic [3:0] sync;
    logic tck_prev;
    logic tck_rise;
    logic tck_fall;
    logic tdi_s;
    logic tms_s;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_meta <= 4'h0;
            sync <= 4'h0;
            tck_prev <= 1'b0;
        end else begin
            sync_meta <= {tms_pin, pin_in};
            sync <= sync_meta;
            tck_prev <= sync[`PIN_TCK];
        end
    end

    assign tdi_s = sync[`PIN_TDI];
    assign tms_s = sync[3];
    // a gated clock: no edge, no activity at all
    assign tck_rise = (roles.tck == `ROLE_TEST) && sync[`PIN_TCK] && !tck_prev;
    assign tck_fall = (roles.tck == `ROLE_TEST) && !sync[`PIN_TCK] && tck_prev;

    // ************************************************************
    // pin roles
    // ************************************************************
    jtag_pin_pkg::pin_roles_t next_roles;
    logic roles_written;

    always_comb begin
        next_roles = role_wr ? role_value : roles;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            roles <= `ROLE_RESET;
            roles_written <= 1'b0;
        end else begin
            roles <= next_roles;
            roles_written <= roles_written | role_wr;
        end
    end

    // ************************************************************
    // tap controller
    // ************************************************************
    jtag_pin_pkg::tap_state_t next_tap;
    jtag_pin_pkg::tap_state_t tap_step;
    logic shifting;

    always_comb begin
        case (tap_state)
            jtag_pin_pkg::TAP_RESET: tap_step = tms_s ? jtag_pin_pkg::TAP_RESET
                                                      : jtag_pin_pkg::TAP_IDLE;
            jtag_pin_pkg::TAP_IDLE: tap_step = tms_s ? jtag_pin_pkg::TAP_SEL_DR
                                                     : jtag_pin_pkg::TAP_IDLE;
            jtag_pin_pkg::TAP_SEL_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_SEL_IR
                                                       : jtag_pin_pkg::TAP_CAPTURE_DR;
            jtag_pin_pkg::TAP_CAPTURE_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_EXIT1_DR
                                                           : jtag_pin_pkg::TAP_SHIFT_DR;
            jtag_pin_pkg::TAP_SHIFT_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_EXIT1_DR
                                                         : jtag_pin_pkg::TAP_SHIFT_DR;
            jtag_pin_pkg::TAP_EXIT1_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_UPDATE_DR
                                                         : jtag_pin_pkg::TAP_PAUSE_DR;
            jtag_pin_pkg::TAP_PAUSE_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_EXIT2_DR
                                                         : jtag_pin_pkg::TAP_PAUSE_DR;
            jtag_pin_pkg::TAP_EXIT2_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_UPDATE_DR
                                                         : jtag_pin_pkg::TAP_SHIFT_DR;
            jtag_pin_pkg::TAP_UPDATE_DR: tap_step = tms_s ? jtag_pin_pkg::TAP_SEL_DR
                                                          : jtag_pin_pkg::TAP_IDLE;
            jtag_pin_pkg::TAP_SEL_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_RESET
                                                       : jtag_pin_pkg::TAP_CAPTURE_IR;
            jtag_pin_pkg::TAP_CAPTURE_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_EXIT1_IR
                                                           : jtag_pin_pkg::TAP_SHIFT_IR;
            jtag_pin_pkg::TAP_SHIFT_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_EXIT1_IR
                                                         : jtag_pin_pkg::TAP_SHIFT_IR;
            jtag_pin_pkg::TAP_EXIT1_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_UPDATE_IR
                                                         : jtag_pin_pkg::TAP_PAUSE_IR;
            jtag_pin_pkg::TAP_PAUSE_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_EXIT2_IR
                                                         : jtag_pin_pkg::TAP_PAUSE_IR;
            jtag_pin_pkg::TAP_EXIT2_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_UPDATE_IR
                                                         : jtag_pin_pkg::TAP_SHIFT_IR;
            jtag_pin_pkg::TAP_UPDATE_IR: tap_step = tms_s ? jtag_pin_pkg::TAP_SEL_DR
                                                          : jtag_pin_pkg::TAP_IDLE;
            default: tap_step = jtag_pin_pkg::TAP_RESET;
        endcase
        next_tap = tck_rise ? tap_step : tap_state;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tap_state <= jtag_pin_pkg::TAP_RESET;
        end else begin
            tap_state <= next_tap;
        end
    end

    assign shifting = (tap_state == jtag_pin_pkg::TAP_SHIFT_DR)
                   || (tap_state == jtag_pin_pkg::TAP_SHIFT_IR);

    // ************************************************************
    // shift path and output bit
    // ************************************************************
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] next_shift_reg;
    logic [CW-1:0] bit_cnt;
    logic [CW-1:0] next_bit_cnt;
    logic tdo_bit;
    logic next_tdo_bit;
    logic push;
    logic next_word_dropped;
    logic capturing;

    assign capturing = (tap_state == jtag_pin_pkg::TAP_CAPTURE_DR)
                    || (tap_state == jtag_pin_pkg::TAP_CAPTURE_IR);
    assign push = tck_rise && shifting && (bit_cnt == CW'(SHIFT_W - 1));

    always_comb begin
        next_shift_reg = shift_reg;
        next_bit_cnt = bit_cnt;
        if (tck_rise && capturing) begin
            next_shift_reg = capture_word;
            next_bit_cnt = '0;
        end else if (tck_rise && shifting) begin
            next_shift_reg = {tdi_s, shift_reg[SHIFT_W-1:1]};
            next_bit_cnt = push ? '0 : bit_cnt + CW'(1);
        end
        // host sees the new bit on its next rising edge
        next_tdo_bit = (tck_fall && shifting) ? shift_reg[0] : tdo_bit;
        // full fifo cannot stall a host-made clock, so the word is lost
        next_word_dropped = word_dropped | (push && !capture_ready);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
            bit_cnt <= '0;
            tdo_bit <= 1'b0;
            word_dropped <= 1'b0;
        end else begin
            shift_reg <= next_shift_reg;
            bit_cnt <= next_bit_cnt;
            tdo_bit <= next_tdo_bit;
            word_dropped <= next_word_dropped;
        end
    end

    stream_fifo #(
        .WIDTH(SHIFT_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(push),
        .in_ready(capture_ready),
        .in_data(next_shift_reg),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    // ************************************************************
    // pin drivers and alternate routing
    // ************************************************************
    logic [1:0] role_of [3];

    assign role_of[0] = roles.tdi;
    assign role_of[1] = roles.tdo;
    assign role_of[2] = roles.tck;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_out[i] = port_d_ctrl.level[i];
            pin_oe_b[i] = !((role_of[i] == `ROLE_GPIO) && port_d_ctrl.dir_out[i]);
        end
        if (roles.tdo == `ROLE_TEST) begin
            pin_out[`PIN_TDO] = tdo_bit;
            pin_oe_b[`PIN_TDO] = !shifting;
        end
    end

    assign port_d_level = sync[2:0];
    assign spi_ss_b = (roles.tdi == `ROLE_ALT) ? tdi_s : 1'b1;

    // ************************************************************
    // checks
    // ************************************************************
    property p_tdo_drive;
        @(posedge ref_clk) disable iff (!rst_b)
        (roles.tdo == `ROLE_TEST) |-> pin_oe_b[`PIN_TDO] == !shifting;
    endproperty
    a_tdo_drive: assert property (p_tdo_drive) else $error("tdo driven outside shift");

    property p_tdo_on_fall;
        @(posedge ref_clk) disable iff (!rst_b)
        !$stable(tdo_bit) |-> $past(tck_fall) && $past(shifting);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off a fall");

    property p_tdi_capture;
        @(posedge ref_clk) disable iff (!rst_b)
        (tck_rise && shifting) |=> shift_reg[SHIFT_W-1] == $past(tdi_s);
    endproperty
    a_tdi_capture: assert property (p_tdi_capture) else $error("tdi bit not captured");

    property p_tap_holds;
        @(posedge ref_clk) disable iff (!rst_b)
        !tck_rise |=> $stable(tap_state);
    endproperty
    a_tap_holds: assert property (p_tap_holds) else $error("tap moved without tck");

    property p_tms_sample;
        @(posedge ref_clk) disable iff (!rst_b)
        (tck_rise && tap_state == jtag_pin_pkg::TAP_IDLE) |=>
            (tap_state == ($past(tms_s) ? jtag_pin_pkg::TAP_SEL_DR : jtag_pin_pkg::TAP_IDLE));
    endproperty
    a_tms_sample: assert property (p_tms_sample) else $error("tms not followed");

    property p_tms_reset;
        @(posedge ref_clk) disable iff (!rst_b)
        (tck_rise && tms_s && tap_state == jtag_pin_pkg::TAP_SEL_IR) |=>
            tap_state == jtag_pin_pkg::TAP_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("tap sequence broken");

    property p_roles_default;
        @(posedge ref_clk) disable iff (!rst_b)
        !roles_written |-> (roles == `ROLE_RESET) && pin_oe_b[`PIN_TDI] && pin_oe_b[`PIN_TCK];
    endproperty
    a_roles_default: assert property (p_roles_default) else $error("pins left test role");

    property p_gpio_drive;
        @(posedge ref_clk) disable iff (!rst_b)
        (roles.tck == `ROLE_GPIO && port_d_ctrl.dir_out[2]) |->
            !pin_oe_b[2] && pin_out[2] == port_d_ctrl.level[2];
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("port d line not driven");

    property p_ss_route;
        @(posedge ref_clk) disable iff (!rst_b)
        (roles.tdi == `ROLE_ALT && $past(roles.tdi) == `ROLE_ALT) |->
            spi_ss_b == $past(pin_in[`PIN_TDI], 2);
    endproperty
    a_ss_route: assert property (p_ss_route) else $error("slave select not routed");

endmodule : jtag_pin_mux

/* verilog/jtag_pin_pkg.sv */
// types shared by the test-port pin block
package jtag_pin_pkg;

    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAPTURE_DR = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAPTURE_IR = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } tap_state_t;

    // role of each shared pin, coded as in the constants header
    typedef struct packed {
        logic [1:0] tck;
        logic [1:0] tdo;
        logic [1:0] tdi;
    } pin_roles_t;

    // port line direction and output level controls for the three shared pins
    typedef struct packed {
        logic [2:0] dir_out;
        logic [2:0] level;
    } port_d_ctrl_t;

endpackage : jtag_pin_pkg

/* verilog/stream_fifo.sv */
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
`include "jtag_pin_consts.svh"

module stream_fifo #(
    parameter int WIDTH = `SHIFT_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("stream_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [PW:0] next_count;
    logic push;
    logic pop;

    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + PW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + PW'(1) : rd_ptr;
        next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; only words below count are ever read out
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    property p_full_refuses;
        @(posedge ref_clk) disable iff (!rst_b)
        (count == (PW+1)'(DEPTH)) |-> !in_ready ##1 (count <= (PW+1)'(DEPTH));
    endproperty
    a_full_refuses: assert property (p_full_refuses) else $error("fifo took a word while full");

endmodule : stream_fifo
